// ---- p3sc_pkg.sv ----
// Shared constants and types for the port 3 serial and control line block
package p3sc_pkg;

  // Receiver and transmitter run on 16 counter/timer 0 ticks per bit
  localparam logic [3:0] P3SC_TICK_LAST = 4'hf;
  localparam logic [3:0] P3SC_TICK_MID = 4'h7;
  localparam logic [3:0] P3SC_TICK_RESET = 4'h0;

  // Transmit frame: start, eight data, two stops, sent bit 0 first
  localparam int unsigned P3SC_TX_FRAME_BITS = 11;
  localparam logic [3:0] P3SC_TX_BIT_LAST = 4'ha;
  localparam logic [3:0] P3SC_TX_BIT_PARITY = 4'h8;
  localparam logic [3:0] P3SC_TX_BIT_STOP = 4'h9;
  localparam logic [3:0] P3SC_TX_BIT_RESET = 4'h0;
  localparam logic [10:0] P3SC_TX_SHIFT_RESET = 11'h7ff;

  localparam logic [2:0] P3SC_RX_BIT_LAST = 3'h7;
  localparam logic [2:0] P3SC_RX_BIT_RESET = 3'h0;
  localparam logic [7:0] P3SC_BYTE_RESET = 8'h00;

  // Idle level of every line and of the synchroniser stages
  localparam logic [3:0] P3SC_LINES_IDLE = 4'hf;
  localparam logic P3SC_LINE_IDLE = 1'b1;
  localparam logic P3SC_PULSE_RESET = 1'b0;

  typedef struct packed {
    logic serial_en;
    logic parity_en;
    logic port_zero_hs_en;
    logic port_two_hs_en;
    logic port_two_bit_seven_is_out;
    logic dm_en;
    logic timer_out_en;
  } p3sc_cfg_type;

  typedef enum logic {P3SC_TX_IDLE, P3SC_TX_SEND} p3sc_tx_state_type;
  typedef enum logic [1:0] {P3SC_RX_IDLE, P3SC_RX_START, P3SC_RX_DATA, P3SC_RX_STOP}
    p3sc_rx_state_type;

endpackage

// ---- p3sc_port3.sv ----
// Port 3 fixed lines with serial transmitter, receiver and control line muxing
// Behaviour
// RULE1 - Eight lines: lines 0-3 are inputs, lines 4-7 outputs, never turned.
// RULE2 - With serial selected, line 0 receives and line 7 transmits.
// RULE3 - Lines carry handshakes, external interrupts, timer in/out, data memory select.
// RULE4 - Port 2 handshake uses input line 1 and output line 6.
// RULE5 - Port 2 bit 7 direction picks data-available versus ready roles.
// RULE6 - Full duplex asynchronous serial, bit rate from counter/timer 0.
// RULE7 - Transmitter adds one start bit and two stop bits itself.
// RULE8 - Exactly eight data bits sent, parity or not.
// RULE9 - Odd parity option replaces the eighth transmitted bit.
// RULE10 - Transmit interrupt raised after every transmitted character.
// RULE11 - Frames carry start, eight data, one or more stops; all accepted.
// RULE12 - With parity, received bit 7 holds the odd parity error flag.
// RULE13 - Each received character raises the receive interrupt, shared with line 0.
// RULE14 - Data memory select on line 4: high for program, low for data loads.
// RULE15 - Software keeps counter/timer 0 in 8-bit mode while serial runs.
// RULE16 - Line 0 external interrupt triggers on a falling edge.
// RULE17 - LSB first; idle and stop bits high, start bit low.
// RULE18 - Receiver finds start edge, samples bits at mid-period on timer ticks.
module p3sc_port3 (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire p3sc_pkg::p3sc_cfg_type cfg_in,
  input wire logic [7:4] port_latch_in,
  input wire logic counter_timer_zero_tick_in,
  input wire logic tx_start_in,
  input wire logic [7:0] tx_data_in,
  output logic tx_busy_out,
  output logic [7:0] rx_data_out,
  output logic rx_valid_out,
  input wire logic program_memory_load_in,
  input wire logic data_memory_load_in,
  input wire logic port_zero_hs_drive_in,
  input wire logic port_two_hs_drive_in,
  input wire logic timer_out_in,
  input wire logic serial_in_line_in,
  input wire logic input_line_one_in,
  input wire logic input_line_two_in,
  input wire logic input_line_three_in,
  output logic output_line_four_out,
  output logic output_line_five_out,
  output logic output_line_six_out,
  output logic serial_out_line_out,
  output logic [3:0] input_lines_out,
  output logic port_two_data_available_n_out,
  output logic port_two_ready_out,
  output logic port_zero_hs_out,
  output logic timer_in_out,
  output logic ext_irq_line_one_out,
  output logic ext_irq_line_two_out,
  output logic ext_irq_line_three_out,
  output logic receive_irq_out,
  output logic transmit_irq_out
);

  logic [3:0] pins;
  logic [3:0] sync1_ff;
  logic [3:0] sync2_ff;
  logic [3:0] sync3_ff;
  logic [3:0] filt_ff;
  logic [3:0] filt_d_ff;
  logic [3:0] fall;
  logic tick;

  p3sc_pkg::p3sc_tx_state_type tx_state_ff;
  logic [10:0] tx_shift_ff;
  logic [7:0] tx_byte_ff;
  logic [3:0] tx_tick_ff;
  logic [3:0] tx_bit_ff;
  logic tx_accept;
  logic tx_done;
  logic tx_line;
  logic tx_bit_seven;

  p3sc_pkg::p3sc_rx_state_type rx_state_ff;
  logic [7:0] rx_shift_ff;
  logic [3:0] rx_tick_ff;
  logic [2:0] rx_bit_ff;
  logic rx_done;
  logic rx_parity_err;

  // Input lines only; outputs are never read back as inputs
  assign pins = {input_line_three_in, input_line_two_in, input_line_one_in,
    serial_in_line_in}; // see RULE1
  assign tick = counter_timer_zero_tick_in; // see RULE6

  // Three-stage synchroniser; a change counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_sync
      always_ff @(posedge clk_in or posedge rst_in)
      begin
        if (rst_in)
        begin
          sync1_ff[gi] <= p3sc_pkg::P3SC_LINE_IDLE;
          sync2_ff[gi] <= p3sc_pkg::P3SC_LINE_IDLE;
          sync3_ff[gi] <= p3sc_pkg::P3SC_LINE_IDLE;
          filt_ff[gi] <= p3sc_pkg::P3SC_LINE_IDLE;
          filt_d_ff[gi] <= p3sc_pkg::P3SC_LINE_IDLE;
        end
        else
        begin
          sync1_ff[gi] <= pins[gi];
          sync2_ff[gi] <= sync1_ff[gi];
          sync3_ff[gi] <= sync2_ff[gi];
          if (sync2_ff[gi] == sync3_ff[gi])
          begin
            filt_ff[gi] <= sync3_ff[gi];
          end
          filt_d_ff[gi] <= filt_ff[gi];
        end
      end
      assign fall[gi] = filt_d_ff[gi] & ~filt_ff[gi];
    end
  endgenerate

  assign input_lines_out = filt_ff;
  assign timer_in_out = filt_ff[1]; // see RULE3
  assign port_zero_hs_out = filt_ff[2]; // see RULE3
  // Port 2 bit 7 as input: line 1 brings data-available; as output: line 1 brings ready
  assign port_two_data_available_n_out = (cfg_in.port_two_hs_en &&
    !cfg_in.port_two_bit_seven_is_out) ? filt_ff[1] : p3sc_pkg::P3SC_LINE_IDLE; // see RULE5
  assign port_two_ready_out = cfg_in.port_two_hs_en && cfg_in.port_two_bit_seven_is_out &&
    filt_ff[1]; // see RULE4

  // Transmitter
  assign tx_accept = (tx_state_ff == p3sc_pkg::P3SC_TX_IDLE) && tx_start_in && cfg_in.serial_en;
  assign tx_done = (tx_state_ff == p3sc_pkg::P3SC_TX_SEND) && tick &&
    (tx_tick_ff == p3sc_pkg::P3SC_TICK_LAST) && (tx_bit_ff == p3sc_pkg::P3SC_TX_BIT_LAST);
  assign tx_bit_seven = cfg_in.parity_en ? ~^tx_data_in[6:0] : tx_data_in[7]; // see RULE9
  assign tx_line = (tx_state_ff == p3sc_pkg::P3SC_TX_SEND) ? tx_shift_ff[0] :
    p3sc_pkg::P3SC_LINE_IDLE; // see RULE17
  assign tx_busy_out = (tx_state_ff == p3sc_pkg::P3SC_TX_SEND);

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      tx_state_ff <= p3sc_pkg::P3SC_TX_IDLE;
      tx_shift_ff <= p3sc_pkg::P3SC_TX_SHIFT_RESET;
      tx_byte_ff <= p3sc_pkg::P3SC_BYTE_RESET;
      tx_tick_ff <= p3sc_pkg::P3SC_TICK_RESET;
      tx_bit_ff <= p3sc_pkg::P3SC_TX_BIT_RESET;
    end
    else
    begin
      case (tx_state_ff)
        p3sc_pkg::P3SC_TX_IDLE:
        begin
          if (tx_accept)
          begin
            // Stops, eight data bits, start; shifted out from bit 0
            tx_shift_ff <= {2'b11, tx_bit_seven, tx_data_in[6:0], 1'b0}; // see RULE7, RULE8
            tx_byte_ff <= {tx_bit_seven, tx_data_in[6:0]};
            tx_tick_ff <= p3sc_pkg::P3SC_TICK_RESET;
            tx_bit_ff <= p3sc_pkg::P3SC_TX_BIT_RESET;
            tx_state_ff <= p3sc_pkg::P3SC_TX_SEND;
          end
        end
        default:
        begin
          if (tick)
          begin
            if (tx_tick_ff == p3sc_pkg::P3SC_TICK_LAST)
            begin
              tx_tick_ff <= p3sc_pkg::P3SC_TICK_RESET;
              if (tx_bit_ff == p3sc_pkg::P3SC_TX_BIT_LAST)
              begin
                tx_state_ff <= p3sc_pkg::P3SC_TX_IDLE;
              end
              else
              begin
                tx_bit_ff <= tx_bit_ff + 4'h1;
                tx_shift_ff <= {1'b1, tx_shift_ff[10:1]}; // see RULE17
              end
            end
            else
            begin
              tx_tick_ff <= tx_tick_ff + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Receiver
  assign rx_done = (rx_state_ff == p3sc_pkg::P3SC_RX_STOP) && tick &&
    (rx_tick_ff == p3sc_pkg::P3SC_TICK_LAST);
  assign rx_parity_err = ~^rx_shift_ff; // see RULE12

  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      rx_state_ff <= p3sc_pkg::P3SC_RX_IDLE;
      rx_shift_ff <= p3sc_pkg::P3SC_BYTE_RESET;
      rx_tick_ff <= p3sc_pkg::P3SC_TICK_RESET;
      rx_bit_ff <= p3sc_pkg::P3SC_RX_BIT_RESET;
      rx_data_out <= p3sc_pkg::P3SC_BYTE_RESET;
      rx_valid_out <= p3sc_pkg::P3SC_PULSE_RESET;
    end
    else
    begin
      rx_valid_out <= rx_done;
      if (rx_done)
      begin
        rx_data_out <= {cfg_in.parity_en ? rx_parity_err : rx_shift_ff[7],
          rx_shift_ff[6:0]}; // see RULE12
      end
      case (rx_state_ff)
        p3sc_pkg::P3SC_RX_IDLE:
        begin
          if (fall[0] && cfg_in.serial_en)
          begin
            rx_tick_ff <= p3sc_pkg::P3SC_TICK_RESET;
            rx_state_ff <= p3sc_pkg::P3SC_RX_START; // see RULE18
          end
        end
        p3sc_pkg::P3SC_RX_START:
        begin
          if (tick)
          begin
            if (rx_tick_ff == p3sc_pkg::P3SC_TICK_MID)
            begin
              // A glitch shorter than half a bit is dropped
              rx_tick_ff <= p3sc_pkg::P3SC_TICK_RESET;
              rx_bit_ff <= p3sc_pkg::P3SC_RX_BIT_RESET;
              rx_state_ff <= filt_ff[0] ? p3sc_pkg::P3SC_RX_IDLE : p3sc_pkg::P3SC_RX_DATA;
            end
            else
            begin
              rx_tick_ff <= rx_tick_ff + 4'h1;
            end
          end
        end
        default:
        begin
          if (tick)
          begin
            if (rx_tick_ff == p3sc_pkg::P3SC_TICK_LAST)
            begin
              rx_tick_ff <= p3sc_pkg::P3SC_TICK_RESET;
              if (rx_state_ff == p3sc_pkg::P3SC_RX_DATA)
              begin
                rx_shift_ff <= {filt_ff[0], rx_shift_ff[7:1]}; // see RULE17, RULE18
                rx_bit_ff <= rx_bit_ff + 3'h1;
                if (rx_bit_ff == p3sc_pkg::P3SC_RX_BIT_LAST)
                begin
                  rx_state_ff <= p3sc_pkg::P3SC_RX_STOP;
                end
              end
              else
              begin
                // First stop done; further stop bits are plain idle time
                rx_state_ff <= p3sc_pkg::P3SC_RX_IDLE; // see RULE11
              end
            end
            else
            begin
              rx_tick_ff <= rx_tick_ff + 4'h1;
            end
          end
        end
      endcase
    end
  end

  // Output lines, each a flop
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      output_line_four_out <= p3sc_pkg::P3SC_LINE_IDLE;
      output_line_five_out <= p3sc_pkg::P3SC_LINE_IDLE;
      output_line_six_out <= p3sc_pkg::P3SC_LINE_IDLE;
      serial_out_line_out <= p3sc_pkg::P3SC_LINE_IDLE;
    end
    else
    begin
      output_line_four_out <= cfg_in.dm_en ? !data_memory_load_in : port_latch_in[4]; // see RULE14
      output_line_five_out <= cfg_in.port_zero_hs_en ? port_zero_hs_drive_in :
        port_latch_in[5]; // see RULE3
      if (cfg_in.port_two_hs_en)
      begin
        output_line_six_out <= port_two_hs_drive_in; // see RULE4
      end
      else if (cfg_in.timer_out_en)
      begin
        output_line_six_out <= timer_out_in; // see RULE3
      end
      else
      begin
        output_line_six_out <= port_latch_in[6];
      end
      serial_out_line_out <= cfg_in.serial_en ? tx_line : port_latch_in[7]; // see RULE2
    end
  end

  // Interrupt request pulses
  always_ff @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ext_irq_line_one_out <= p3sc_pkg::P3SC_PULSE_RESET;
      ext_irq_line_two_out <= p3sc_pkg::P3SC_PULSE_RESET;
      ext_irq_line_three_out <= p3sc_pkg::P3SC_PULSE_RESET;
      receive_irq_out <= p3sc_pkg::P3SC_PULSE_RESET;
      transmit_irq_out <= p3sc_pkg::P3SC_PULSE_RESET;
    end
    else
    begin
      ext_irq_line_one_out <= fall[1];
      ext_irq_line_two_out <= fall[2];
      ext_irq_line_three_out <= fall[3];
      receive_irq_out <= (fall[0] && !cfg_in.serial_en) || rx_done; // see RULE13, RULE16
      transmit_irq_out <= tx_done; // see RULE10
    end
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in);

  sequence s_tx_accept;
    tx_accept;
  endsequence
  sequence s_start_bit_out;
    ##2 !serial_out_line_out;
  endsequence

  chk_tx_start_low: assert property (s_tx_accept |-> s_start_bit_out) // see RULE7
    else $error("start bit not driven low");
  chk_tx_irq_end: assert property ($fell(tx_busy_out) |-> transmit_irq_out) // see RULE10
    else $error("transmit interrupt missing at end of frame");
  chk_tx_stop_high: assert property (tx_busy_out && tx_bit_ff >= p3sc_pkg::P3SC_TX_BIT_STOP
    && cfg_in.serial_en |=> serial_out_line_out) // see RULE7
    else $error("stop bit not high");
  // With parity the eighth bit and data bits 0-6 carry an odd count of ones
  chk_tx_parity_bit: assert property (tx_busy_out && tx_bit_ff == p3sc_pkg::P3SC_TX_BIT_PARITY
    && cfg_in.serial_en |=> ^{serial_out_line_out, tx_byte_ff[6:0]} ==
    (cfg_in.parity_en || ^tx_byte_ff)) // see RULE9
    else $error("eighth transmitted bit wrong");
  chk_dm_data_low: assert property (cfg_in.dm_en && data_memory_load_in |=>
    !output_line_four_out) // see RULE14
    else $error("data memory select not low on data load");
  chk_dm_prog_high: assert property (cfg_in.dm_en && program_memory_load_in &&
    !data_memory_load_in |=> output_line_four_out) // see RULE14
    else $error("data memory select active on program load");
  chk_rx_irq_pair: assert property (rx_valid_out |-> receive_irq_out) // see RULE13
    else $error("received character without interrupt");
  chk_line0_fall_irq: assert property (!cfg_in.serial_en && $fell(filt_ff[0]) |=>
    receive_irq_out) // see RULE16
    else $error("line 0 falling edge missed");
  chk_p2_hs_drive: assert property (cfg_in.port_two_hs_en |=>
    output_line_six_out == $past(port_two_hs_drive_in)) // see RULE4
    else $error("port 2 handshake not on line 6");

endmodule

// ---- p3sc_remote.sv ----
// Remote asynchronous serial node facing the port 3 serial pair
module p3sc_remote #(
  parameter int BIT_CYCLES = 32
) (
  input wire logic clk_in,
  input wire logic line_from_dut_in,
  output logic line_to_dut_out,
  output logic [10:0] frame_out,
  output logic frame_valid_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [10:0] shift;
  initial
  begin
    line_to_dut_out = 1'b1;
    frame_valid_out = 1'b0;
    frame_out = 11'h000;
  end
  // Start low, data lowest bit first, then stops high for the given count
  task automatic send_byte(input logic [7:0] data, input int stops);
    logic [9:0] bits;
    bits = {1'b1, data, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(negedge clk_in);
      line_to_dut_out = bits[i];
      repeat (BIT_CYCLES - 1) @(negedge clk_in);
    end
    repeat (BIT_CYCLES * (stops - 1)) @(negedge clk_in);
  endtask
  // Samples start, data and both stops at mid-bit
  always
  begin
    @(negedge line_from_dut_in);
    repeat (BIT_CYCLES / 2) @(posedge clk_in);
    for (int i = 0; i < 11; i++)
    begin
      shift[i] = line_from_dut_in;
      if (i < 10)
        repeat (BIT_CYCLES) @(posedge clk_in);
    end
    frame_out <= shift;
    frame_valid_out <= 1'b1;
    @(posedge clk_in);
    frame_valid_out <= 1'b0;
  end
endmodule

// ---- p3sc_tb.sv ----
// Self-checking bench for the port 3 serial and control line block
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in;
  logic rst_in;
  p3sc_pkg::p3sc_cfg_type cfg;
  logic [7:4] latch;
  logic tick = 1'b0;
  logic tx_start, tx_busy, rx_valid, remote_tx, serial_out;
  logic [7:0] tx_data, rx_data;
  logic pm_load, dm_load, p0_drive, p2_drive, tout;
  logic line_one, line_two, line_three;
  logic [6:4] out_lines;
  logic [3:0] in_lines;
  logic dav_n, ready, p0_hs, t_in, ext_irq_line_three, ext_irq_line_one, receive_irq, rx_irq, tx_irq;
  logic [10:0] frame;
  logic frame_valid;
  logic [2:0] prev;
  int fail_count = 0;
  int check_count = 0;
  int cycles = 0;
  int seed = 26;
  int n_tx_irq = 0;
  int n_rx_irq = 0;
  int n_ext = 0;
  int exp_ext = 0;
  logic [7:0] exp_rx_q[$];
  logic [10:0] exp_tx_q[$];

  p3sc_port3 u_p3sc_port3 (.clk_in(clk_in), .rst_in(rst_in), .cfg_in(cfg),
    .port_latch_in(latch), .counter_timer_zero_tick_in(tick), .tx_start_in(tx_start),
    .tx_data_in(tx_data), .tx_busy_out(tx_busy), .rx_data_out(rx_data),
    .rx_valid_out(rx_valid), .program_memory_load_in(pm_load),
    .data_memory_load_in(dm_load), .port_zero_hs_drive_in(p0_drive),
    .port_two_hs_drive_in(p2_drive), .timer_out_in(tout), .serial_in_line_in(remote_tx),
    .input_line_one_in(line_one), .input_line_two_in(line_two),
    .input_line_three_in(line_three), .output_line_four_out(out_lines[4]),
    .output_line_five_out(out_lines[5]), .output_line_six_out(out_lines[6]),
    .serial_out_line_out(serial_out), .input_lines_out(in_lines),
    .port_two_data_available_n_out(dav_n), .port_two_ready_out(ready),
    .port_zero_hs_out(p0_hs), .timer_in_out(t_in), .ext_irq_line_one_out(ext_irq_line_three),
    .ext_irq_line_two_out(ext_irq_line_one), .ext_irq_line_three_out(receive_irq),
    .receive_irq_out(rx_irq), .transmit_irq_out(tx_irq));

  p3sc_remote u_p3sc_remote (.clk_in(clk_in), .line_from_dut_in(serial_out),
    .line_to_dut_out(remote_tx), .frame_out(frame), .frame_valid_out(frame_valid));

  initial
  begin
    clk_in = 1'b0;
    forever #5 clk_in = ~clk_in;
  end

  // Timer 0 bit clock held at a fixed 8-bit rate, one tick every two cycles
  always @(negedge clk_in) tick <= ~tick;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic send_tx(input logic [7:0] d);
    int w;
    w = 0;
    @(negedge clk_in);
    tx_data = d;
    tx_start = 1'b1;
    exp_tx_q.push_back({2'b11, cfg.parity_en ? {~^d[6:0], d[6:0]} : d, 1'b0});
    @(negedge clk_in);
    tx_start = 1'b0;
    while (tx_busy === 1'b1 && w < 600)
    begin
      @(negedge clk_in);
      w++;
    end
    if (w == 600)
      fail_count++;
  endtask

  // Result watcher: takes the oldest expectation whenever a received byte, or a frame with serial enabled, shows up
  always @(posedge clk_in)
  begin
    cycles++;
    if (cycles > 8000)
    begin
      fail_count++;
      tally_and_finish();
    end
    else
    begin
      if (tx_irq === 1'b1)
        n_tx_irq++;
      if (rx_irq === 1'b1)
        n_rx_irq++;
      n_ext += $countones({ext_irq_line_three, ext_irq_line_one, receive_irq});
      if (rx_valid === 1'b1)
        check({7'h00, rx_irq, rx_data}, {8'h01, exp_rx_q.pop_front()});
      if (frame_valid === 1'b1 && cfg.serial_en === 1'b1)
        check({5'h00, frame}, {5'h00, exp_tx_q.pop_front()});
    end
  end

  initial
  begin
    rst_in = 1'b1;
    cfg = p3sc_pkg::p3sc_cfg_type'(7'h00);
    latch = 4'hf;
    {tx_start, pm_load, dm_load, p0_drive, p2_drive, tout} = 6'h00;
    tx_data = 8'h00;
    {line_one, line_two, line_three} = 3'h7;
    repeat (10) @(negedge clk_in);
    check({out_lines, serial_out, tx_busy, rx_valid}, 16'h003c);
    rst_in = 1'b0;
    cfg.serial_en = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      cfg.parity_en = p[0];
      fork
        for (int i = 0; i < 4; i++)
          send_tx(8'($random(seed)));
        for (int i = 0; i < 4; i++)
        begin
          logic [7:0] b;
          b = 8'($random(seed));
          exp_rx_q.push_back(cfg.parity_en ? {~^b, b[6:0]} : b);
          u_p3sc_remote.send_byte(b, 1 + i % 2);
        end
      join
      repeat (100) @(negedge clk_in);
      $display("serial test with parity %0d done", p);
    end
    check(16'(n_tx_irq), 16'h0008);
    cfg.serial_en = 1'b0;
    u_p3sc_remote.send_byte(8'hff, 1);
    repeat (20) @(negedge clk_in);
    check(16'(n_rx_irq), 16'h0009);
    $display("line zero edge test done");
    for (int i = 0; i < 16; i++)
    begin
      prev = {line_one, line_two, line_three};
      {cfg.dm_en, cfg.port_zero_hs_en, cfg.port_two_hs_en, cfg.port_two_bit_seven_is_out,
        cfg.timer_out_en, latch, pm_load, dm_load, p0_drive, p2_drive, tout, line_one,
        line_two, line_three} = 17'($random(seed));
      exp_ext += $countones(prev & ~{line_one, line_two, line_three});
      repeat (6) @(negedge clk_in);
      check({out_lines, serial_out, dav_n, ready, p0_hs, t_in, in_lines},
        {cfg.port_two_hs_en ? p2_drive : (cfg.timer_out_en ? tout : latch[6]),
        cfg.port_zero_hs_en ? p0_drive : latch[5], cfg.dm_en ? ~dm_load : latch[4],
        latch[7], ~(cfg.port_two_hs_en & ~cfg.port_two_bit_seven_is_out) | line_one,
        cfg.port_two_hs_en & cfg.port_two_bit_seven_is_out & line_one,
        line_two, line_one, line_three, line_two, line_one,
        remote_tx});
    end
    repeat (10) @(negedge clk_in);
    check(16'(n_ext), 16'(exp_ext));
    $display("line function test done");
    tally_and_finish();
  end
endmodule
